// ---- src/pbo_regs.vh ----
// Constants for the port B alternate-function pin override block
`ifndef PBO_REGS_VH
`define PBO_REGS_VH
`define PBO_BIT_SCK        7
`define PBO_BIT_MISO       6
`define PBO_BIT_MOSI       5
`define PBO_BIT_SS         4
`define PBO_BIT_OC0        3
`define PBO_BIT_EXT_IRQ_LINE_TWO       2
`define PBO_BIT_T1         1
`define PBO_BIT_T0         0
`define PBO_PORT_W         8
`define PBO_RST_BYTE       8'h00
`define PBO_RST_BIT        1'b0
`endif

// ---- src/pbo_pin_cell.v ----
// One pin's override merge: override signals applied to the port registers
`timescale 1ns/10ps
`default_nettype none
module pbo_pin_cell (
  input  wire clk_i,
  input  wire rst_n,
  input  wire direction_bit_i,
  input  wire output_latch_i,
  input  wire pullup_disable_i,
  input  wire pullup_override_enable_i,
  input  wire pullup_override_value_i,
  input  wire direction_override_enable_i,
  input  wire direction_override_value_i,
  input  wire port_value_override_enable_i,
  input  wire port_value_override_value_i,
  output reg  pin_oe_o,
  output reg  pin_out_o,
  output reg  pin_pullup_o
);
  wire next_oe;
  wire next_out;
  wire next_pullup;

  assign next_oe  = direction_override_enable_i ?
                    direction_override_value_i : direction_bit_i;
  assign next_out = port_value_override_enable_i ?
                    port_value_override_value_i : output_latch_i;
  // Unless overridden, pull-up only acts while the pin is an input and latch bit is high
  assign next_pullup = pullup_override_enable_i ? pullup_override_value_i :
                       (~next_oe & output_latch_i & ~pullup_disable_i);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_o     <= 1'b0;
      pin_out_o    <= 1'b0;
      pin_pullup_o <= 1'b0;
    end else begin
      pin_oe_o     <= next_oe;
      pin_out_o    <= next_out;
      pin_pullup_o <= next_pullup;
    end
  end
endmodule
`default_nettype wire

// ---- src/pbo_top.v ----
// Port A/B alternate-function pin override logic
// Contract
// [RULE1] SPI slave: SCK pin 7 forced to input, direction bit ignored.
// [RULE2] SPI master: SCK direction follows pin7 direction bit.
// [RULE3] SPI-forced inputs keep pull-up under output latch control.
// [RULE4] SPI master: MISO pin 6 forced to input.
// [RULE5] SPI slave: MISO direction follows pin6 direction bit.
// [RULE6] SPI slave: MOSI pin 5 forced to input.
// [RULE7] SPI master: MOSI direction follows pin5 direction bit.
// [RULE8] SPI slave: SS pin 4 forced to input.
// [RULE9] Slave SPI active only while SS pin is held low.
// [RULE10] SPI master: SS direction follows pin4 direction bit.
// [RULE11] Timer0 compare output reaches pin 3 only when its direction is out.
// [RULE12] Pin 3 also carries timer0 PWM waveform.
// [RULE13] Software should make comparator pins inputs without pull-ups.
// [RULE14] Pin 2 routes to external interrupt line two.
// [RULE15] Port A overrides all zero; pins feed analog channels only.
// [RULE16] Pins 7..4 map to SPI SCK, MISO, MOSI, SS.
// [RULE17] Pin 0 feeds timer0 count and serial clock; pin 1 timer1 count.
// [RULE18] SPI disabled: SPI pins are plain port pins.
`timescale 1ns/10ps
`default_nettype none
`include "pbo_regs.vh"
module pbo_top #(
  parameter PORT_W = `PBO_PORT_W
) (
  input  wire              clk_i,
  input  wire              rst_n_i,
  input  wire [PORT_W-1:0] portb_direction_i,
  input  wire [PORT_W-1:0] portb_output_latch_i,
  input  wire [PORT_W-1:0] portb_pin_i,
  input  wire              pullup_disable_i,
  input  wire              spi_enable_i,
  input  wire              spi_master_i,
  input  wire              spi_sck_out_i,
  input  wire              spi_mosi_out_i,
  input  wire              spi_miso_out_i,
  input  wire              timer0_compare_enable_i,
  input  wire              timer0_compare_out_i,
  input  wire [PORT_W-1:0] porta_pin_i,
  input  wire [PORT_W-1:0] porta_direction_i,
  input  wire [PORT_W-1:0] porta_output_latch_i,
  output reg  [PORT_W-1:0] portb_oe_o,
  output reg  [PORT_W-1:0] portb_out_o,
  output reg  [PORT_W-1:0] portb_pullup_o,
  output reg  [PORT_W-1:0] porta_oe_o,
  output reg  [PORT_W-1:0] porta_out_o,
  output reg  [PORT_W-1:0] porta_pullup_o,
  output reg  [PORT_W-1:0] analog_io_path_o,
  output reg               spi_sck_in_o,
  output reg               spi_miso_in_o,
  output reg               spi_mosi_in_o,
  output reg               spi_slave_active_o,
  output reg               ext_irq_line_two_o,
  output reg               comparator_pos_in_o,
  output reg               comparator_neg_in_o,
  output reg               timer0_ext_count_in_o,
  output reg               timer1_ext_count_in_o,
  output reg               serial_port_ext_clock_o
);
  reg              rst_meta;
  reg              rst_n;
  reg  [PORT_W-1:0] pullup_override_enable;
  reg  [PORT_W-1:0] pullup_override_value;
  reg  [PORT_W-1:0] direction_override_enable;
  reg  [PORT_W-1:0] direction_override_value;
  reg  [PORT_W-1:0] port_value_override_enable;
  reg  [PORT_W-1:0] port_value_override_value;
  wire [PORT_W-1:0] cell_oe;
  wire [PORT_W-1:0] cell_out;
  wire [PORT_W-1:0] cell_pullup;
  wire             spi_slave;
  wire             spi_master;

  // Reset release through two flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign spi_slave  = spi_enable_i & ~spi_master_i;
  assign spi_master = spi_enable_i & spi_master_i;

  // Override signal table for port B
  always @* begin
    pullup_override_enable     = `PBO_RST_BYTE;
    pullup_override_value      = `PBO_RST_BYTE;
    direction_override_enable  = `PBO_RST_BYTE;
    direction_override_value   = `PBO_RST_BYTE;
    port_value_override_enable = `PBO_RST_BYTE;
    port_value_override_value  = `PBO_RST_BYTE;
    // Forced inputs leave pull-up override off so latch keeps control
    direction_override_enable[`PBO_BIT_SCK]  = spi_slave; // [RULE1]
    direction_override_enable[`PBO_BIT_MISO] = spi_master; // [RULE4]
    direction_override_enable[`PBO_BIT_MOSI] = spi_slave; // [RULE6]
    // Master leaves the select pin to its direction bit, no override
    direction_override_enable[`PBO_BIT_SS]   = spi_slave; // [RULE8] [RULE10]
    // SPI drives value on its output pins; direction stays software's
    port_value_override_enable[`PBO_BIT_SCK]  = spi_master; // [RULE2]
    port_value_override_value[`PBO_BIT_SCK]   = spi_sck_out_i; // [RULE16]
    port_value_override_enable[`PBO_BIT_MOSI] = spi_master; // [RULE7]
    port_value_override_value[`PBO_BIT_MOSI]  = spi_mosi_out_i;
    // Slave output driven whenever enabled as slave, whatever the SS pin level
    port_value_override_enable[`PBO_BIT_MISO] = spi_slave; // [RULE5]
    port_value_override_value[`PBO_BIT_MISO]  = spi_miso_out_i;
    // Timer0 waveform, compare or PWM; direction bit gates visibility
    port_value_override_enable[`PBO_BIT_OC0] = timer0_compare_enable_i; // [RULE12]
    port_value_override_value[`PBO_BIT_OC0]  = timer0_compare_out_i; // [RULE11]
  end

  genvar g;
  generate
    for (g = 0; g < PORT_W; g = g + 1) begin : g_cell
      pbo_pin_cell u_cell (
        .clk_i                        (clk_i),
        .rst_n                        (rst_n),
        .direction_bit_i              (portb_direction_i[g]),
        .output_latch_i               (portb_output_latch_i[g]),
        .pullup_disable_i             (pullup_disable_i),
        .pullup_override_enable_i     (pullup_override_enable[g]),
        .pullup_override_value_i      (pullup_override_value[g]),
        .direction_override_enable_i  (direction_override_enable[g]),
        .direction_override_value_i   (direction_override_value[g]),
        .port_value_override_enable_i (port_value_override_enable[g]),
        .port_value_override_value_i  (port_value_override_value[g]),
        .pin_oe_o                     (cell_oe[g]),
        .pin_out_o                    (cell_out[g]),
        .pin_pullup_o                 (cell_pullup[g])
      );
    end
  endgenerate

  // Every port B output is registered once; cells hold the flop
  always @* begin
    portb_oe_o     = cell_oe; // [RULE18]
    portb_out_o    = cell_out;
    portb_pullup_o = cell_pullup; // [RULE3]
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      porta_oe_o              <= `PBO_RST_BYTE;
      porta_out_o             <= `PBO_RST_BYTE;
      porta_pullup_o          <= `PBO_RST_BYTE;
      analog_io_path_o        <= `PBO_RST_BYTE;
      spi_sck_in_o            <= `PBO_RST_BIT;
      spi_miso_in_o           <= `PBO_RST_BIT;
      spi_mosi_in_o           <= `PBO_RST_BIT;
      spi_slave_active_o      <= `PBO_RST_BIT;
      ext_irq_line_two_o      <= `PBO_RST_BIT;
      comparator_pos_in_o     <= `PBO_RST_BIT;
      comparator_neg_in_o     <= `PBO_RST_BIT;
      timer0_ext_count_in_o   <= `PBO_RST_BIT;
      timer1_ext_count_in_o   <= `PBO_RST_BIT;
      serial_port_ext_clock_o <= `PBO_RST_BIT;
    end else begin
      // Port A: no overrides, plain port plus analog channel
      porta_oe_o       <= porta_direction_i; // [RULE15]
      porta_out_o      <= porta_output_latch_i;
      porta_pullup_o   <= porta_output_latch_i & ~porta_direction_i &
                          {PORT_W{~pullup_disable_i}};
      analog_io_path_o <= porta_pin_i; // [RULE15]
      spi_sck_in_o     <= portb_pin_i[`PBO_BIT_SCK]; // [RULE16]
      spi_miso_in_o    <= portb_pin_i[`PBO_BIT_MISO];
      spi_mosi_in_o    <= portb_pin_i[`PBO_BIT_MOSI];
      // Select low while enabled as slave
      spi_slave_active_o <= spi_slave & ~portb_pin_i[`PBO_BIT_SS]; // [RULE9]
      ext_irq_line_two_o <= portb_pin_i[`PBO_BIT_EXT_IRQ_LINE_TWO]; // [RULE14]
      // Comparator taps the raw pin; software keeps it input, no pull-up
      comparator_pos_in_o <= portb_pin_i[`PBO_BIT_EXT_IRQ_LINE_TWO]; // [RULE13]
      comparator_neg_in_o <= portb_pin_i[`PBO_BIT_OC0];
      timer0_ext_count_in_o   <= portb_pin_i[`PBO_BIT_T0]; // [RULE17]
      serial_port_ext_clock_o <= portb_pin_i[`PBO_BIT_T0];
      timer1_ext_count_in_o   <= portb_pin_i[`PBO_BIT_T1];
    end
  end
endmodule
`default_nettype wire

// ---- verif/pbo_chk.sv ----
// Port-level assertions for the port B pin override block
`timescale 1ns/10ps
`default_nettype none
module pbo_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] portb_direction_i,
  input wire logic [7:0] portb_output_latch_i,
  input wire logic [7:0] portb_pin_i,
  input wire logic       pullup_disable_i,
  input wire logic       spi_enable_i,
  input wire logic       spi_master_i,
  input wire logic       spi_miso_out_i,
  input wire logic       timer0_compare_enable_i,
  input wire logic       timer0_compare_out_i,
  input wire logic [7:0] portb_oe_o,
  input wire logic [7:0] portb_out_o,
  input wire logic [7:0] portb_pullup_o,
  input wire logic       spi_slave_active_o
);
  logic [1:0] up;
  wire        sl = spi_enable_i & ~spi_master_i;
  wire        ms = spi_enable_i & spi_master_i;
  // Outputs only track inputs from the third edge after release
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) up <= 2'd0;
    else if (up != 2'd3) up <= up + 2'd1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || up != 2'd3);
  slave_in_a: assert property ($past(sl) |-> !portb_oe_o[7]
    && !portb_oe_o[5] && !portb_oe_o[4]) else $error("slave pin driven");
  master_dir_a: assert property ($past(ms) |-> {portb_oe_o[7],
    portb_oe_o[5:4]} == $past({portb_direction_i[7], portb_direction_i[5:4]}))
    else $error("master pin direction wrong");
  forced_pull_a: assert property ($past(sl && !pullup_disable_i) |->
    portb_pullup_o[7] == $past(portb_output_latch_i[7])) else $error("pullup");
  master_miso_a: assert property ($past(ms) |-> !portb_oe_o[6])
    else $error("master input pin driven");
  slave_miso_a: assert property ($past(sl) |-> portb_out_o[6] ==
    $past(spi_miso_out_i) && portb_oe_o[6] == $past(portb_direction_i[6]))
    else $error("slave output pin wrong");
  slave_act_a: assert property (spi_slave_active_o ==
    $past(sl && !portb_pin_i[4])) else $error("slave active wrong");
  cmp_out_a: assert property ($past(timer0_compare_enable_i) |->
    portb_out_o[3] == $past(timer0_compare_out_i) &&
    portb_oe_o[3] == $past(portb_direction_i[3])) else $error("compare pin");
  plain_a: assert property (!$past(spi_enable_i) |->
    portb_oe_o[7:4] == $past(portb_direction_i[7:4])) else $error("plain pin");
  cover property (spi_slave_active_o);
  cover property ($past(ms) && portb_oe_o[7]);
  cover property ($past(timer0_compare_enable_i) && portb_oe_o[3]);
endmodule
`default_nettype wire

// ---- verif/pbo_ext_dev.sv ----
// Far side of the port B pins: remote SPI party and other pin drivers
`timescale 1ns/10ps
`default_nettype none
module pbo_ext_dev (
  input  wire logic       clk_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] drv_en_i,
  input  wire logic [7:0] drv_val_i,
  output var  logic [7:0] pin_o
);
  logic [7:0] drift = 8'h00;
  // A floating pin wanders, so nothing may rely on its last level
  always @(posedge clk_i) drift <= ~drift;
  always @* pin_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_val_i)
    | (~oe_i & ~drv_en_i & (pullup_i | drift));
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the port B pin override block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, pullup_disable_i = 1'b0;
  logic spi_enable_i = 1'b0, spi_master_i = 1'b0, spi_sck_out_i = 1'b0;
  logic spi_mosi_out_i = 1'b0, spi_miso_out_i = 1'b0;
  logic timer0_compare_enable_i = 1'b0, timer0_compare_out_i = 1'b0;
  logic [7:0] portb_direction_i = 8'h00, portb_output_latch_i = 8'h00;
  logic [7:0] porta_pin_i = 8'h00, den = 8'h00, dval = 8'h00, portb_pin_i;
  logic [7:0] porta_direction_i = 8'h00, porta_output_latch_i = 8'h00;
  wire [7:0] portb_oe_o, portb_out_o, portb_pullup_o, porta_oe_o, porta_out_o;
  wire [7:0] porta_pullup_o, analog_io_path_o;
  wire spi_sck_in_o, spi_miso_in_o, spi_mosi_in_o, spi_slave_active_o;
  wire ext_irq_line_two_o, comparator_pos_in_o, comparator_neg_in_o;
  wire timer0_ext_count_in_o, timer1_ext_count_in_o, serial_port_ext_clock_o;
  int errors = 0, check_count = 0;
  // Rows: enable, master, direction, latch, expected oe, expected pull-up
  logic [33:0] rows [5] = '{{2'b00, 32'hf0ff_f00f}, {2'b10, 32'hffff_4fb0},
    {2'b11, 32'hffff_bf40}, {2'b11, 32'h00ff_00ff}, {2'b10, 32'hff0f_4f00}};
  pbo_top uut (.*);
  pbo_ext_dev ext (.clk_i, .oe_i(portb_oe_o), .out_i(portb_out_o),
    .pullup_i(portb_pullup_o), .drv_en_i(den), .drv_val_i(dval),
    .pin_o(portb_pin_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic print_verdict;
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    chk(portb_oe_o, 8'h00, "oe in reset");
    rst_n_i <= 1'b1;
    step();
    foreach (rows[i]) begin
      @(posedge clk_i);
      {spi_enable_i, spi_master_i, portb_direction_i} <= rows[i][33:24];
      portb_output_latch_i <= rows[i][23:16];
      step();
      chk(portb_oe_o, rows[i][15:8], "oe");
      chk(portb_pullup_o, rows[i][7:0], "pullup");
    end
    @(posedge clk_i);
    {spi_enable_i, spi_master_i, spi_sck_out_i, spi_mosi_out_i} <= 4'hf;
    portb_direction_i <= 8'hff;
    step();
    chk(portb_out_o & 8'ha0, 8'ha0, "master outs");
    @(posedge clk_i);
    {spi_master_i, spi_miso_out_i, den, dval} <= {2'b01, 16'h1000};
    step();
    chk(portb_out_o & 8'h40, 8'h40, "slave out");
    chk({7'h0, spi_slave_active_o}, 8'h01, "selected");
    @(posedge clk_i);
    dval <= 8'h10;
    step();
    chk({7'h0, spi_slave_active_o}, 8'h00, "deselected");
    @(posedge clk_i);
    {spi_enable_i, timer0_compare_enable_i, timer0_compare_out_i} <= 3'b011;
    {portb_direction_i, portb_output_latch_i} <= 16'h0800;
    step();
    chk(portb_out_o & portb_oe_o & 8'h08, 8'h08, "compare pin");
    @(posedge clk_i);
    // Comparator pins as inputs with pull-ups off
    {portb_direction_i, den, dval, porta_pin_i} <= 32'h00_ff_e5_5a;
    porta_output_latch_i <= 8'h3c;
    step();
    chk(portb_oe_o, 8'h00, "compare off");
    chk({ext_irq_line_two_o, timer0_ext_count_in_o, serial_port_ext_clock_o,
      timer1_ext_count_in_o, 4'h0}, 8'he0, "routes");
    chk(analog_io_path_o | porta_oe_o, 8'h5a, "port a");
    chk({spi_sck_in_o, spi_miso_in_o, spi_mosi_in_o, comparator_pos_in_o,
      comparator_neg_in_o, 3'h0}, 8'hf0, "spi and comparator taps");
    chk(porta_out_o, 8'h3c, "port a out");
    chk(porta_pullup_o, 8'h3c, "port a pullup");
    @(posedge clk_i);
    {pullup_disable_i, portb_output_latch_i} <= 9'h1ff;
    step();
    chk(portb_pullup_o, 8'h00, "pullup off");
    chk(porta_pullup_o, 8'h00, "port a pullup off");
    // Reset in mid-run clears every registered output at once
    rst_n_i <= 1'b0;
    step();
    chk(portb_oe_o | portb_out_o | porta_out_o, 8'h00, "mid reset");
    rst_n_i <= 1'b1;
    step();
    chk(porta_out_o, 8'h3c, "after reset");
    print_verdict();
  end
endmodule
bind pbo_top pbo_chk u_chk (.clk_i, .rst_n_i, .portb_direction_i,
  .portb_output_latch_i, .portb_pin_i, .pullup_disable_i, .spi_enable_i,
  .spi_master_i, .spi_miso_out_i, .timer0_compare_enable_i,
  .timer0_compare_out_i, .portb_oe_o, .portb_out_o, .portb_pullup_o,
  .spi_slave_active_o);
`default_nettype wire
